// File: logic/frw_ctrl.sv
// frw_ctrl.sv - apb-driven controller that runs flash rewrite commands on the sequencer
//
// Summary of operation
// R1 - mode a: device keeps erasing or programming while ram-vectored interrupts run
// R2 - device aborts and resets flash on watchdog, osc-stop or voltage interrupt
// R3 - after a forced abort the controller re-runs the erase of that block
// R4 - watchdog keeps counting during commands, so it is refreshed periodically
// R5 - mode b erase suspend: interrupt suspends erase; writing 0 resumes it
// R6 - mode b erase without suspend: interrupt waits until erase completes
// R7 - mode b program suspend: interrupt suspends programming; writing 0 resumes it
// R8 - mode b program without suspend: interrupt waits until programming completes
// R9 - long mode b erasures refresh the watchdog inside an erase suspend
// R10 - address-match interrupt is disabled while any command runs
// R11 - non-maskable interrupt is disabled while block 0 is erased
// R12 - guarded bits are written 0 then 1 back to back, interrupts held off
// R13 - mode a commands only start when the cpu clock is at most 5 mhz
// R14 - software avoids trap and breakpoint instructions in mode a
// R15 - an already programmed address is never programmed again before an erase
// R16 - stop and wait requests are blocked while an erase is suspended
// R17 - the suspend latency is the device's; the controller waits for its flag
//
// The APB slave port and the register offsets are this design's own decisions.
`default_nettype none
`include "frw_defines.svh"
module frw_ctrl #(
	parameter int ADDR_W = 8,
	parameter int BLK_W = 2,
	parameter int SRC_HZ = 20000000,
	parameter int MAX_RETRY = 2,
	parameter int WDT_CYC = `FRW_WDT_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic dev_busy,
	input wire logic dev_suspended,
	input wire logic dev_abort,
	input wire logic maskable_irq_in,
	output logic cpu_rewrite_mode_b,
	output logic erase_suspend_enable,
	output logic program_suspend_enable,
	output logic erase_suspend_request_bit,
	output logic program_suspend_request_bit,
	output logic dev_erase_start,
	output logic dev_prog_start,
	output logic [ADDR_W-1:0] dev_addr,
	output logic dev_guard_wr,
	output logic [2:0] dev_guard_data,
	output logic dev_irq_req,
	output logic dev_wdt_refresh,
	output logic dev_nmi_en,
	output logic dev_addr_match_en,
	output logic dev_stop_req,
	output logic dev_wait_req,
	output logic cpu_clock_divide_enable,
	output logic cpu_clock_divide_sel_lo,
	output logic cpu_clock_divide_sel_hi
);
	import frw_pkg::*;

	frw_state_t state;
	frw_op_t op;
	logic [`FRW_CTRL_W-1:0] ctrl;
	logic [ADDR_W-1:0] addr;
	logic [2:0] guard;
	logic [`FRW_EV_W-1:0] irq_stat;
	logic [`FRW_EV_W-1:0] irq_mask;
	logic [`FRW_EV_W-1:0] ev;
	logic dirty [2**ADDR_W];
	logic [1:0] retries;
	logic busy_seen;
	logic busy_s;
	logic susp_s;
	logic abort_s;
	logic mirq_s;
	logic abort_d;
	logic susp_d;
	logic susp_rise;
	logic tick;
	logic wr_en;
	logic rd_en;
	logic mapped;
	logic cmd_wr;
	logic clk_ok;
	logic susp_refresh;
	logic [31:0] next_rdata;

	generate
		if (BLK_W < 1 || BLK_W >= ADDR_W || ADDR_W > 12 || MAX_RETRY > 3) begin : g_chk
			$error("frw_ctrl parameters out of range");
		end
	endgenerate

	frw_sync #(.W(4)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({dev_busy, dev_suspended, dev_abort, maskable_irq_in}),
		.q({busy_s, susp_s, abort_s, mirq_s})
	);

	frw_tick #(.PERIOD(WDT_CYC)) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.en(ctrl[`FRW_CTRL_WDT_EN]),
		.tick(tick)
	);

	// apb: pready rises in the first access cycle, so no wait states
	assign wr_en = psel && penable && pready && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign cmd_wr = wr_en && paddr == `FRW_OFF_CMD;
	always_comb begin
		mapped = 1'b1;
		next_rdata = 32'h0000_0000;
		case (paddr)
			`FRW_OFF_CTRL: next_rdata[`FRW_CTRL_W-1:0] = ctrl;
			`FRW_OFF_ADDR: next_rdata[ADDR_W-1:0] = addr;
			`FRW_OFF_CMD: next_rdata = 32'h0000_0000;
			`FRW_OFF_GUARD: next_rdata[2:0] = guard;
			`FRW_OFF_STATUS: next_rdata[6:0] = {dirty[addr], susp_s, busy_s, state};
			`FRW_OFF_IRQ_STAT: next_rdata[`FRW_EV_W-1:0] = irq_stat;
			`FRW_OFF_IRQ_MASK: next_rdata[`FRW_EV_W-1:0] = irq_mask;
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			if (rd_en) begin
				prdata <= mapped ? next_rdata : 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `FRW_CTRL_RESET;
			addr <= '0;
			guard <= 3'h0;
			irq_mask <= `FRW_IRQ_RESET;
		end else if (wr_en) begin
			case (paddr)
				`FRW_OFF_CTRL: ctrl <= pwdata[`FRW_CTRL_W-1:0];
				`FRW_OFF_ADDR: addr <= pwdata[ADDR_W-1:0];
				`FRW_OFF_GUARD: guard <= pwdata[2:0];
				`FRW_OFF_IRQ_MASK: irq_mask <= pwdata[`FRW_EV_W-1:0];
				default: ;
			endcase
		end
	end

	// divider code: off is /1, else {hi,lo} selects /2, /4, /8, /16
	function automatic logic div_ok(input logic en, input logic hi, input logic lo);
		int div;
		div = en ? (2 << {hi, lo}) : 1;
		return (SRC_HZ / div) <= `FRW_MODE_A_MAX_HZ;
	endfunction
	assign clk_ok = ctrl[`FRW_CTRL_MODE_B] ||
		div_ok(ctrl[`FRW_CTRL_DIV_EN], ctrl[`FRW_CTRL_DIV_HI], ctrl[`FRW_CTRL_DIV_LO]); // R13

	// refresh inside a suspend only where the device can suspend the erase
	assign susp_refresh = ctrl[`FRW_CTRL_MODE_B] && ctrl[`FRW_CTRL_ESUS_EN] &&
		op == frw_op_erase; // R9

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abort_d <= 1'b0;
			susp_d <= 1'b0;
		end else begin
			abort_d <= abort_s;
			susp_d <= susp_s;
		end
	end

	// the synced flag lingers for a few cycles after a restart, so only its rise counts
	assign susp_rise = susp_s && !susp_d;

	always_comb begin
		ev = '0;
		ev[`FRW_EV_ABORT] = abort_s && !abort_d; // R2
		ev[`FRW_EV_DONE] = state == frw_st_run && busy_seen && !busy_s && !susp_s;
		ev[`FRW_EV_SUSP] = state == frw_st_run && susp_rise;
		ev[`FRW_EV_REFUSED] = cmd_wr && (pwdata[`FRW_CMD_ERASE] || pwdata[`FRW_CMD_PROGRAM]) &&
			(state != frw_st_idle || !clk_ok ||
			(pwdata[`FRW_CMD_PROGRAM] && dirty[addr])); // R13 R15
		ev[`FRW_EV_RETRY_FAIL] = state == frw_st_recover && !busy_s &&
			retries == 2'(MAX_RETRY);
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= `FRW_IRQ_RESET;
			irq <= 1'b0;
		end else begin
			if (wr_en && paddr == `FRW_OFF_IRQ_STAT) begin
				irq_stat <= (irq_stat & ~pwdata[`FRW_EV_W-1:0]) | ev;
			end else begin
				irq_stat <= irq_stat | ev;
			end
			irq <= |(irq_stat & irq_mask);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= frw_st_idle;
			op <= frw_op_erase;
			retries <= 2'h0;
			busy_seen <= 1'b0;
		end else begin
			case (state)
				frw_st_idle: begin
					if (cmd_wr && pwdata[`FRW_CMD_GUARD]) begin
						state <= frw_st_guard0;
					end else if (cmd_wr && !ev[`FRW_EV_REFUSED]) begin
						if (pwdata[`FRW_CMD_ERASE]) begin
							op <= frw_op_erase;
							retries <= 2'h0;
							state <= frw_st_start;
						end else if (pwdata[`FRW_CMD_PROGRAM]) begin
							op <= frw_op_program;
							retries <= 2'h0;
							state <= frw_st_start;
						end
					end
				end
				frw_st_guard0: state <= frw_st_guard1; // R12
				frw_st_guard1: state <= frw_st_idle;
				frw_st_start: begin
					busy_seen <= 1'b0;
					state <= frw_st_run;
				end
				frw_st_run: begin
					if (busy_s) begin
						busy_seen <= 1'b1;
					end
					if (ev[`FRW_EV_ABORT]) begin
						state <= frw_st_recover;
					end else if (susp_rise) begin
						state <= frw_st_susp; // R5 R7 R17
					end else if (ev[`FRW_EV_DONE]) begin
						state <= frw_st_idle; // R6 R8
					end else if (tick && susp_refresh) begin
						state <= frw_st_rsusp; // R9
					end
				end
				frw_st_rsusp: begin
					if (ev[`FRW_EV_ABORT]) begin
						state <= frw_st_recover;
					end else if (susp_rise) begin
						state <= frw_st_run;
					end
				end
				frw_st_susp: begin
					if (cmd_wr && pwdata[`FRW_CMD_RESUME]) begin
						state <= frw_st_run;
					end
				end
				frw_st_recover: begin
					// aborted contents are unreliable: erase the block again
					if (!busy_s) begin
						if (retries == 2'(MAX_RETRY)) begin
							state <= frw_st_idle;
						end else begin
							retries <= retries + 2'h1;
							op <= frw_op_erase;
							state <= frw_st_start; // R3
						end
					end
				end
				default: state <= frw_st_idle;
			endcase
		end
	end

	// a programmed address stays marked until its block is erased
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2**ADDR_W; i++) begin
				dirty[i] <= 1'b0;
			end
		end else if (state == frw_st_start) begin
			if (op == frw_op_program) begin
				dirty[addr] <= 1'b1; // R15
			end else begin
				for (int i = 0; i < 2**ADDR_W; i++) begin
					if (i[ADDR_W-1:ADDR_W-BLK_W] == addr[ADDR_W-1:ADDR_W-BLK_W]) begin
						dirty[i] <= 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_erase_start <= 1'b0;
			dev_prog_start <= 1'b0;
			dev_addr <= '0;
			dev_guard_wr <= 1'b0;
			dev_guard_data <= 3'h0;
		end else begin
			dev_erase_start <= state == frw_st_start && op == frw_op_erase;
			dev_prog_start <= state == frw_st_start && op == frw_op_program;
			if (state == frw_st_start) begin
				dev_addr <= addr;
			end
			dev_guard_wr <= state == frw_st_guard0 || state == frw_st_guard1;
			dev_guard_data <= state == frw_st_guard0 ? 3'h0 : guard; // R12
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erase_suspend_request_bit <= 1'b0;
			program_suspend_request_bit <= 1'b0;
			dev_wdt_refresh <= 1'b0;
		end else begin
			// request bit stays 1 while suspended; writing 0 restarts the operation
			erase_suspend_request_bit <= op == frw_op_erase &&
				(state == frw_st_susp || state == frw_st_rsusp ||
				(state == frw_st_run && (susp_rise || (tick && susp_refresh)))) &&
				!(cmd_wr && pwdata[`FRW_CMD_RESUME]) &&
				!(state == frw_st_rsusp && susp_rise); // R5 R9
			program_suspend_request_bit <= op == frw_op_program &&
				(state == frw_st_susp || (state == frw_st_run && susp_rise)) &&
				!(cmd_wr && pwdata[`FRW_CMD_RESUME]); // R7
			dev_wdt_refresh <= (tick && !(state == frw_st_run && susp_refresh)) ||
				(state == frw_st_rsusp && susp_rise); // R4 R9
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_rewrite_mode_b <= 1'b0;
			erase_suspend_enable <= 1'b0;
			program_suspend_enable <= 1'b0;
			dev_irq_req <= 1'b0;
			dev_nmi_en <= 1'b0;
			dev_addr_match_en <= 1'b0;
			dev_stop_req <= 1'b0;
			dev_wait_req <= 1'b0;
			cpu_clock_divide_enable <= 1'b0;
			cpu_clock_divide_sel_lo <= 1'b0;
			cpu_clock_divide_sel_hi <= 1'b0;
		end else begin
			cpu_rewrite_mode_b <= ctrl[`FRW_CTRL_MODE_B];
			erase_suspend_enable <= ctrl[`FRW_CTRL_ESUS_EN];
			program_suspend_enable <= ctrl[`FRW_CTRL_PSUS_EN];
			// the request is masked, not latched, across the guarded pair; a level still high passes after it
			dev_irq_req <= mirq_s && state != frw_st_guard0 && state != frw_st_guard1; // R1 R12
			dev_nmi_en <= ctrl[`FRW_CTRL_NMI_EN] && !(state != frw_st_idle &&
				op == frw_op_erase && addr[ADDR_W-1:ADDR_W-BLK_W] == '0); // R11
			dev_addr_match_en <= ctrl[`FRW_CTRL_AM_EN] && state == frw_st_idle && !busy_s; // R10
			dev_stop_req <= ctrl[`FRW_CTRL_STOP] && !susp_s && state != frw_st_susp; // R16
			dev_wait_req <= ctrl[`FRW_CTRL_WAIT] && !susp_s && state != frw_st_susp; // R16
			cpu_clock_divide_enable <= ctrl[`FRW_CTRL_DIV_EN];
			cpu_clock_divide_sel_lo <= ctrl[`FRW_CTRL_DIV_LO];
			cpu_clock_divide_sel_hi <= ctrl[`FRW_CTRL_DIV_HI];
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_abort_reerase: assert property ( // R3
		state == frw_st_recover && !busy_s && retries != 2'(MAX_RETRY) |=> ##1 dev_erase_start)
		else $error("no erase reissued after abort");
	chk_wdt_direct: assert property ( // R4
		tick && !(state == frw_st_run && susp_refresh) && state != frw_st_rsusp |=> dev_wdt_refresh)
		else $error("watchdog tick not forwarded");
	chk_suspend_refresh: assert property ( // R9
		state == frw_st_run && tick && susp_refresh && !susp_s && !ev[`FRW_EV_ABORT]
		|=> erase_suspend_request_bit && !dev_wdt_refresh)
		else $error("refresh did not go through erase suspend");
	chk_am_off_busy: assert property ( // R10
		busy_s |=> !dev_addr_match_en)
		else $error("address match enabled during command");
	chk_nmi_block0: assert property ( // R11
		dev_erase_start && dev_addr[ADDR_W-1:ADDR_W-BLK_W] == '0 |-> !dev_nmi_en)
		else $error("nmi enabled during block 0 erase");
	chk_guard_pair: assert property ( // R12
		dev_guard_wr && dev_guard_data == 3'h0 && !$past(dev_guard_wr)
		|=> dev_guard_wr && dev_guard_data == $past(guard) && !dev_irq_req)
		else $error("guarded pair not back to back");
	chk_guard_irq_held: assert property ( // R12
		dev_guard_wr |-> !dev_irq_req)
		else $error("interrupt passed between guarded writes");
	chk_mode_a_clock: assert property ( // R13
		state == frw_st_idle && cmd_wr && !pwdata[`FRW_CMD_GUARD] && !clk_ok &&
		(pwdata[`FRW_CMD_ERASE] || pwdata[`FRW_CMD_PROGRAM]) |=> state == frw_st_idle)
		else $error("command started with fast cpu clock");
	chk_no_reprogram: assert property ( // R15
		state == frw_st_idle && cmd_wr && pwdata[`FRW_CMD_PROGRAM] && !pwdata[`FRW_CMD_GUARD] &&
		!pwdata[`FRW_CMD_ERASE] && dirty[addr] |=> state == frw_st_idle ##1 irq_stat[`FRW_EV_REFUSED])
		else $error("second program to programmed address");
	chk_no_stop_susp: assert property ( // R16
		susp_s |=> !dev_stop_req && !dev_wait_req)
		else $error("stop or wait while suspended");
endmodule
`default_nettype wire

// File: logic/frw_defines.svh
// frw_defines.svh - register offsets, fields, reset values and timing counts of the controller
`ifndef FRW_DEFINES_SVH
`define FRW_DEFINES_SVH
`define FRW_OFF_CTRL 12'h000
`define FRW_OFF_ADDR 12'h004
`define FRW_OFF_CMD 12'h008
`define FRW_OFF_GUARD 12'h00c
`define FRW_OFF_STATUS 12'h010
`define FRW_OFF_IRQ_STAT 12'h014
`define FRW_OFF_IRQ_MASK 12'h018
`define FRW_CTRL_MODE_B 0
`define FRW_CTRL_ESUS_EN 1
`define FRW_CTRL_PSUS_EN 2
`define FRW_CTRL_WDT_EN 3
`define FRW_CTRL_NMI_EN 4
`define FRW_CTRL_AM_EN 5
`define FRW_CTRL_STOP 6
`define FRW_CTRL_WAIT 7
`define FRW_CTRL_DIV_LO 8
`define FRW_CTRL_DIV_HI 9
`define FRW_CTRL_DIV_EN 10
`define FRW_CTRL_W 11
`define FRW_CTRL_RESET 11'h000
`define FRW_CMD_ERASE 0
`define FRW_CMD_PROGRAM 1
`define FRW_CMD_RESUME 2
`define FRW_CMD_GUARD 3
`define FRW_EV_DONE 0
`define FRW_EV_ABORT 1
`define FRW_EV_SUSP 2
`define FRW_EV_REFUSED 3
`define FRW_EV_RETRY_FAIL 4
`define FRW_EV_W 5
`define FRW_IRQ_RESET 5'h00
`define FRW_CLK_PERIOD_NS 40
`define FRW_WDT_PERIOD_NS 100000
`define FRW_WDT_CYCLES (`FRW_WDT_PERIOD_NS / `FRW_CLK_PERIOD_NS)
`define FRW_MODE_A_MAX_HZ 5000000
`endif

// File: logic/frw_pkg.sv
// frw_pkg.sv - types shared by the rewrite controller
`default_nettype none
package frw_pkg;
	typedef enum logic [3:0] {
		frw_st_idle,
		frw_st_guard0,
		frw_st_guard1,
		frw_st_start,
		frw_st_run,
		frw_st_rsusp,
		frw_st_susp,
		frw_st_recover
	} frw_state_t;
	typedef enum logic {
		frw_op_erase,
		frw_op_program
	} frw_op_t;
endpackage
`default_nettype wire

// File: logic/frw_sync.sv
// frw_sync.sv - two-flop synchroniser, one per bit
`default_nettype none
module frw_sync #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	generate
		for (genvar i = 0; i < W; i++) begin : g_bit
			logic meta;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					meta <= d[i];
					q[i] <= meta;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// File: logic/frw_tick.sv
// frw_tick.sv - periodic one-cycle enable pulse for watchdog refresh
`default_nettype none
module frw_tick #(
	parameter int PERIOD = 2500
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic en,
	output logic tick
);
	logic [$clog2(PERIOD+1)-1:0] cnt;
	generate
		if (PERIOD < 2) begin : g_chk
			$error("frw_tick period too short");
		end
	endgenerate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (!en) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (cnt == ($clog2(PERIOD+1))'(PERIOD - 1)) begin
			cnt <= '0;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: tb/frw_dev_model.sv
// behavioural model of the flash sequencer on the far side of the controller
`default_nettype none
module frw_dev_model #(
	parameter int OP_CYC = 40,
	parameter int SUS_LAT = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic erase_start,
	input wire logic prog_start,
	input wire logic mode_b,
	input wire logic esus_en,
	input wire logic psus_en,
	input wire logic esus_req,
	input wire logic psus_req,
	input wire logic irq_req,
	input wire logic abort_cmd,
	output logic busy,
	output logic suspended,
	output logic abort
);
	timeunit 1ns;
	timeprecision 1ps;
	logic op_erase;
	logic seen;
	logic req;
	logic trig;
	int cnt;
	int lat;
	assign req = op_erase ? esus_req : psus_req;
	// mode a never suspends, so ram-vectored handlers run beside the operation
	assign trig = mode_b && (op_erase ? esus_en : psus_en) && (irq_req || req);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'b0;
			suspended <= 1'b0;
			abort <= 1'b0;
			op_erase <= 1'b0;
			seen <= 1'b0;
			cnt <= 0;
			lat <= 0;
		end else begin
			abort <= abort_cmd && busy;
			if (abort_cmd && busy) begin
				busy <= 1'b0;
				suspended <= 1'b0;
			end else if (erase_start || prog_start) begin
				busy <= 1'b1;
				cnt <= OP_CYC;
				op_erase <= erase_start;
				lat <= 0;
			end else if (suspended) begin
				if (seen && !req) begin
					suspended <= 1'b0;
					seen <= 1'b0;
				end else begin
					seen <= seen || req;
				end
			end else if (busy && trig) begin
				lat <= lat + 1;
				if (lat == SUS_LAT - 1) begin
					suspended <= 1'b1;
					lat <= 0;
				end
			end else if (busy) begin
				lat <= 0;
				cnt <= cnt - 1;
				if (cnt == 1) begin
					busy <= 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: tb/test_flash_rewrite_interrupt_control.sv
// self-checking bench for the flash rewrite controller
`default_nettype none
`include "frw_defines.svh"
module test_flash_rewrite_interrupt_control;
	timeunit 1ns;
	timeprecision 1ps;
	import frw_pkg::*;
`define CHECK(n, e, g) check(n, 32'(e), 32'(g))
`define WAIT(c) for (int k = 0; k < 300 && !(c); k++) @(posedge pclk)
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic mirq = 1'b0, abort_cmd = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, irq, busy, susp, abrt, mode_b, esus_en, psus_en;
	logic esus_req, psus_req, estart, pstart, gwr, irq_req, wdt_ref, stop_req, nmi_en, am_en;
	logic [2:0] gdata;
	logic [7:0] daddr;
	int errors = 0, n_tests = 0, cyc = 0;
	always #20 pclk = ~pclk;
	// period long enough for a suspend round trip to leave the erase room to progress
	frw_ctrl #(.WDT_CYC(32)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.dev_busy(busy), .dev_suspended(susp), .dev_abort(abrt), .maskable_irq_in(mirq),
		.cpu_rewrite_mode_b(mode_b), .erase_suspend_enable(esus_en),
		.program_suspend_enable(psus_en), .erase_suspend_request_bit(esus_req),
		.program_suspend_request_bit(psus_req), .dev_erase_start(estart),
		.dev_prog_start(pstart), .dev_addr(daddr), .dev_guard_wr(gwr),
		.dev_guard_data(gdata), .dev_irq_req(irq_req), .dev_wdt_refresh(wdt_ref),
		.dev_nmi_en(nmi_en), .dev_addr_match_en(am_en), .dev_stop_req(stop_req), .dev_wait_req(),
		.cpu_clock_divide_enable(), .cpu_clock_divide_sel_lo(), .cpu_clock_divide_sel_hi());
	frw_dev_model dev (.pclk(pclk), .presetn(presetn), .erase_start(estart),
		.prog_start(pstart), .mode_b(mode_b), .esus_en(esus_en), .psus_en(psus_en),
		.esus_req(esus_req), .psus_req(psus_req), .irq_req(irq_req),
		.abort_cmd(abort_cmd), .busy(busy), .suspended(susp), .abort(abrt));
	task check(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// one apb transfer; a gap edge first so psel is never assigned twice in a step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task start(input logic [31:0] ctrl, input logic [31:0] a, input logic [31:0] cmd);
		apb(1'b1, `FRW_OFF_CTRL, ctrl);
		apb(1'b1, `FRW_OFF_ADDR, a);
		apb(1'b1, `FRW_OFF_CMD, cmd);
	endtask
	task stat_clear(input logic [4:0] e);
		`WAIT(irq === 1'b1);
		apb(1'b0, `FRW_OFF_IRQ_STAT, 32'h0);
		`CHECK("irq_stat", e, rd);
		apb(1'b1, `FRW_OFF_IRQ_STAT, 32'h1f);
		`WAIT(irq === 1'b0);
		`CHECK("irq_clear", 1'b0, irq);
	endtask
	task t_reset;
		apb(1'b0, `FRW_OFF_STATUS, 32'h0);
		`CHECK("status_rst", 32'h0, rd);
		apb(1'b0, `FRW_OFF_CTRL, 32'h0);
		`CHECK("ctrl_rst", 32'h0, rd);
		apb(1'b0, 12'h020, 32'h0);
		`CHECK("unmapped_err", 1'b1, err);
		`CHECK("unmapped_rd", 32'h0, rd);
		$display("reset test done");
	endtask
	task t_mode_a;
		apb(1'b1, `FRW_OFF_IRQ_MASK, 32'h1f);
		start(32'h500, 32'h45, 32'h1);
		`WAIT(estart === 1'b1);
		`CHECK("erase_start", 1'b1, estart);
		`CHECK("erase_addr", 8'h45, daddr);
		mirq <= 1'b1;
		stat_clear(5'h01);
		`CHECK("irq_pass", 1'b1, irq_req);
		mirq <= 1'b0;
		$display("mode a erase test done");
	endtask
	task t_refuse;
		start(32'h500, 32'h45, 32'h2);
		stat_clear(5'h01);
		apb(1'b1, `FRW_OFF_CMD, 32'h2);
		stat_clear(5'h08);
		start(32'h0, 32'h46, 32'h1);
		stat_clear(5'h08);
		$display("refusal test done");
	endtask
	task t_esusp;
		start(32'h43, 32'h80, 32'h1);
		`WAIT(busy === 1'b1);
		mirq <= 1'b1;
		`WAIT(esus_req === 1'b1);
		`CHECK("esus_req", 1'b1, esus_req);
		`CHECK("stop_blocked", 1'b0, stop_req);
		apb(1'b0, `FRW_OFF_STATUS, 32'h0);
		`CHECK("state_susp", 4'h6, rd[3:0]);
		mirq <= 1'b0;
		apb(1'b1, `FRW_OFF_CMD, 32'h4);
		`WAIT(esus_req === 1'b0);
		`CHECK("esus_drop", 1'b0, esus_req);
		`WAIT(busy === 1'b0);
		repeat (4) @(posedge pclk);
		stat_clear(5'h05);
		`CHECK("stop_idle", 1'b1, stop_req);
		$display("erase suspend test done");
	endtask
	task t_prog;
		start(32'h03, 32'h81, 32'h2);
		`WAIT(busy === 1'b1);
		mirq <= 1'b1;
		stat_clear(5'h01);
		mirq <= 1'b0;
		start(32'h05, 32'h82, 32'h2);
		`WAIT(busy === 1'b1);
		mirq <= 1'b1;
		`WAIT(psus_req === 1'b1);
		`CHECK("psus_req", 1'b1, psus_req);
		mirq <= 1'b0;
		apb(1'b1, `FRW_OFF_CMD, 32'h4);
		`WAIT(psus_req === 1'b0);
		`CHECK("psus_drop", 1'b0, psus_req);
		`WAIT(busy === 1'b0);
		repeat (4) @(posedge pclk);
		stat_clear(5'h05);
		$display("program suspend test done");
	endtask
	task t_wdt_susp;
		start(32'h3b, 32'h00, 32'h1);
		`WAIT(esus_req === 1'b1);
		`CHECK("wsus_req", 1'b1, esus_req);
		`CHECK("wsus_noref", 1'b0, wdt_ref);
		`CHECK("nmi_block0", 1'b0, nmi_en);
		`CHECK("am_busy", 1'b0, am_en);
		`WAIT(wdt_ref === 1'b1);
		`CHECK("wsus_ref", 1'b1, wdt_ref);
		`CHECK("wsus_drop", 1'b0, esus_req);
		`WAIT(busy === 1'b0);
		repeat (4) @(posedge pclk);
		stat_clear(5'h01);
		`CHECK("nmi_idle", 1'b1, nmi_en);
		`CHECK("am_idle", 1'b1, am_en);
		apb(1'b1, `FRW_OFF_CTRL, 32'h0);
		$display("watchdog suspend test done");
	endtask
	task t_guard;
		apb(1'b1, `FRW_OFF_GUARD, 32'h5);
		mirq <= 1'b1;
		apb(1'b1, `FRW_OFF_CMD, 32'h8);
		`WAIT(gwr === 1'b1);
		`CHECK("guard_zero", 3'h0, gdata);
		`CHECK("guard_irq0", 1'b0, irq_req);
		@(posedge pclk);
		`CHECK("guard_wr1", 1'b1, gwr);
		`CHECK("guard_one", 3'h5, gdata);
		`CHECK("guard_irq1", 1'b0, irq_req);
		@(posedge pclk);
		`CHECK("guard_end", 1'b0, gwr);
		mirq <= 1'b0;
		$display("guard test done");
	endtask
	task t_abort;
		start(32'h500, 32'h45, 32'h1);
		`WAIT(busy === 1'b1);
		abort_cmd <= 1'b1;
		@(posedge pclk);
		abort_cmd <= 1'b0;
		`WAIT(estart === 1'b1);
		`CHECK("re_erase", 1'b1, estart);
		`CHECK("re_addr", 8'h45, daddr);
		`WAIT(busy === 1'b0);
		apb(1'b0, `FRW_OFF_IRQ_STAT, 32'h0);
		`CHECK("abort_flag", 1'b1, rd[1]);
		apb(1'b1, `FRW_OFF_IRQ_STAT, 32'h1f);
		$display("abort test done");
	endtask
	task t_wdt;
		apb(1'b1, `FRW_OFF_CTRL, 32'h508);
		`WAIT(wdt_ref === 1'b1);
		`CHECK("wdt_refresh", 1'b1, wdt_ref);
		apb(1'b1, `FRW_OFF_CTRL, 32'h0);
		$display("watchdog test done");
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ceiling well above the several hundred cycles the tests need
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			report_and_stop;
		end
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_mode_a;
		t_refuse;
		t_esusp;
		t_prog;
		t_wdt_susp;
		t_guard;
		t_abort;
		t_wdt;
		report_and_stop;
	end
endmodule
`default_nettype wire
